//--- rtl/tooth_pkg.sv
// constants for the crank tooth conditioner parameter block
// Operation
// - zero cranking register selects running parameter set
// - nonzero cranking register selects cranking parameter set
// - four-bit threshold code from active register
// - threshold in upper nibble, default 0101
// - one-shot blanking, fraction of last pulse
// - blanked comparator result drives tooth output
// - optional divided tooth output drives tachometer
// - automatic threshold mode from zero crossing and decay timer
// - blanking code lower nibble, 1/32 steps
// - zero crossing forces maximum, then decays
`default_nettype none
package tooth_pkg;
    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam logic [7:0]  RUN_OFS    = 8'h00;      // engine running parameters
    localparam logic [7:0]  CRANK_OFS  = 8'h04;      // engine cranking parameters
    localparam logic [7:0]  AUTO_OFS   = 8'h08;      // automatic decay mantissa/exponent
    localparam logic [7:0]  MISC_OFS   = 8'h0C;      // mode and tacho control
    localparam logic [7:0]  STAT_OFS   = 8'h10;      // read-only state
    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0]  RUN_RST    = 8'h50;      // threshold 0101, no blanking
    localparam logic [7:0]  CRANK_RST  = 8'h00;
    localparam logic [7:0]  AUTO_RST   = 8'h00;
    localparam logic [7:0]  MISC_RST   = 8'h00;
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int          THR_LSB    = 4;          // threshold nibble base
    localparam int          BLK_LSB    = 0;          // blanking nibble base
    localparam int          AUTO_BIT   = 7;          // misc: automatic mode
    localparam int          DIV_LSB    = 4;          // misc: tacho divide, 3 bits
    localparam int          HLREF_BIT  = 0;          // misc: low pulse reference
    localparam int          MANT_LSB   = 0;          // auto: mantissa nibble
    localparam int          EXP_LSB    = 4;          // auto: exponent nibble
    // ************************************************************
    // codes and timing
    // ************************************************************
    localparam logic [3:0]  THR_MAX    = 4'hF;       // highest comparator threshold
    localparam int          BLK_SHIFT  = 5;          // code/32 of the reference pulse
    localparam int          DECAY_W    = 20;         // decay step timer width
    localparam logic [1:0]  RESP_OKAY  = 2'b00;
    localparam logic [1:0]  RESP_SLV   = 2'b10;
endpackage
`default_nettype wire

//--- rtl/crank_tooth_conditioner_params.sv
// parameter selection, threshold, blanking and tacho logic with axi4-lite registers
`default_nettype none
module crank_tooth_conditioner_params #(
    parameter int CNT_W = 20                         // pulse width counter bits
) (
    input  wire logic                  core_clk,
    input  wire logic                  rst_n,
    input  wire logic                  clk_en,
    // comparator result and zero crossing sign from the front end
    input  wire logic                  sensor_cmp,
    input  wire logic                  sensor_zero_pos,
    output logic [3:0]                 thresh_dac_code,
    output logic                       conditioned_tooth_out,
    output logic                       tacho_drive_out,
    // axi4-lite slave
    input  wire logic [7:0]            s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [7:0]            s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready
);
    import tooth_pkg::*;

    // the decay and blanking math needs at least the decay timer width
    if (CNT_W < DECAY_W) begin : g_chk
        $error("CNT_W must be at least DECAY_W");
    end

    // ************************************************************
    // register bus
    // ************************************************************
    logic [7:0]       run_reg;                       // running parameter set
    logic [7:0]       crank_reg;                     // cranking parameter set
    logic [7:0]       auto_reg;                      // decay mantissa/exponent
    logic [7:0]       misc_reg;                      // mode bits
    logic [7:0]       aw_addr_reg;                   // latched write address
    logic [7:0]       w_data_reg;                    // latched write byte
    logic             w_lane_reg;                    // byte lane 0 enabled
    logic [3:0]       thr_code_reg;                  // code driven to the dac

    wire aw_take  = s_axi_awvalid & s_axi_awready;
    wire w_take   = s_axi_wvalid & s_axi_wready;
    wire ar_take  = s_axi_arvalid & s_axi_arready;
    // both halves held and no response pending: commit the write now
    wire wr_fire  = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
    wire wr_hit   = (aw_addr_reg == RUN_OFS) | (aw_addr_reg == CRANK_OFS)
                  | (aw_addr_reg == AUTO_OFS) | (aw_addr_reg == MISC_OFS);
    wire wr_en    = wr_fire & wr_hit & w_lane_reg;
    wire rd_hit   = (s_axi_araddr == RUN_OFS) | (s_axi_araddr == CRANK_OFS)
                  | (s_axi_araddr == AUTO_OFS) | (s_axi_araddr == MISC_OFS)
                  | (s_axi_araddr == STAT_OFS);

    // ************************************************************
    // active parameter set
    // ************************************************************
    wire       crank_on   = (crank_reg != 8'h00);
    wire [7:0] active_set = crank_on ? crank_reg : run_reg;
    wire [3:0] sel_thr    = active_set[THR_LSB +: 4];
    wire [3:0] sel_blk    = active_set[BLK_LSB +: 4];
    wire       auto_on    = misc_reg[AUTO_BIT];
    wire       low_ref    = misc_reg[HLREF_BIT];
    wire [2:0] tach_div   = misc_reg[DIV_LSB +: 3];
    wire [7:0] status     = {thr_code_reg, crank_on, conditioned_tooth_out, 2'b00};

    // read mux; unmapped addresses read zero
    wire [7:0] rd_byte = (s_axi_araddr == RUN_OFS)   ? run_reg   :
                         (s_axi_araddr == CRANK_OFS) ? crank_reg :
                         (s_axi_araddr == AUTO_OFS)  ? auto_reg  :
                         (s_axi_araddr == MISC_OFS)  ? misc_reg  :
                         (s_axi_araddr == STAT_OFS)  ? status    : 8'h00;

    // write channel: address and data are caught independently
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            aw_addr_reg   <= 8'h00;
            w_data_reg    <= 8'h00;
            w_lane_reg    <= 1'b0;
        end else if (clk_en) begin
            if (aw_take) begin
                s_axi_awready <= 1'b0;
                aw_addr_reg   <= s_axi_awaddr;
            end
            if (w_take) begin
                s_axi_wready  <= 1'b0;
                w_data_reg    <= s_axi_wdata[7:0];
                w_lane_reg    <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                s_axi_bvalid  <= 1'b1;
                s_axi_bresp   <= wr_hit ? RESP_OKAY : RESP_SLV;
            end else if (s_axi_bvalid && s_axi_bready) begin
                // response taken: open both channels again
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // software registers; only lane 0 carries bits, the rest read zero
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            run_reg   <= RUN_RST;
            crank_reg <= CRANK_RST;
            auto_reg  <= AUTO_RST;
            misc_reg  <= MISC_RST;
        end else if (clk_en && wr_en) begin
            case (aw_addr_reg)
                RUN_OFS:   run_reg   <= w_data_reg;
                CRANK_OFS: crank_reg <= w_data_reg;
                AUTO_OFS:  auto_reg  <= w_data_reg;
                MISC_OFS:  misc_reg  <= w_data_reg;
                default:   ;
            endcase
        end
    end

    // read channel: data is captured with the address, one read at a time
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (clk_en) begin
            if (ar_take) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= {24'h00_0000, rd_byte};
                s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLV;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ************************************************************
    // threshold: manual or automatic decay
    // ************************************************************
    logic                zc_prev_reg;                // last zero crossing sign
    logic [DECAY_W-1:0]  decay_cnt_reg;              // cycles to next decay step

    wire                 zc_rise    = sensor_zero_pos & ~zc_prev_reg;
    // step period is ((16 + mantissa) << exponent) + 1 cycles: the reload
    // edge itself counts, exponent kept below 16
    wire [DECAY_W-1:0]   decay_load =
        DECAY_W'({1'b1, auto_reg[MANT_LSB +: 4]}) << auto_reg[EXP_LSB +: 4];
    wire                 decay_step = (decay_cnt_reg == '0);

    // the dac code follows the active set; in auto mode it jumps to the top
    // at each rising zero crossing and walks down one code per step period
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            zc_prev_reg   <= 1'b0;
            thr_code_reg  <= RUN_RST[THR_LSB +: 4];
            decay_cnt_reg <= '0;
        end else if (clk_en) begin
            zc_prev_reg <= sensor_zero_pos;
            if (!auto_on) begin
                thr_code_reg <= sel_thr;
            end else if (zc_rise) begin
                thr_code_reg  <= THR_MAX;
                decay_cnt_reg <= decay_load;
            end else if (thr_code_reg <= sel_thr) begin
                // never sit below the selected threshold
                thr_code_reg <= sel_thr;
            end else if (decay_step) begin
                thr_code_reg  <= thr_code_reg - 4'h1;
                decay_cnt_reg <= decay_load;
            end else begin
                decay_cnt_reg <= decay_cnt_reg - DECAY_W'(1);
            end
        end
    end
    assign thresh_dac_code = thr_code_reg;

    // ************************************************************
    // pulse measurement and one-shot blanking
    // ************************************************************
    logic [CNT_W-1:0]    pulse_cnt_reg;              // running width of current output level
    logic [CNT_W-1:0]    last_ref_reg;               // last completed reference pulse
    logic [CNT_W-1:0]    blank_cnt_reg;              // cycles left in the blank window
    logic                out_reg;                    // conditioned tooth level

    wire                 ref_level  = ~low_ref;      // level whose width is measured
    wire                 out_change = (sensor_cmp != out_reg) && (blank_cnt_reg == '0);
    // a change that ends the reference pulse uses that pulse itself
    wire                 ref_ending = out_change && (out_reg == ref_level);
    wire [CNT_W-1:0]     ref_len    = ref_ending ? pulse_cnt_reg : last_ref_reg;
    // blank length = reference * code / 32; the product is widened first
    wire [CNT_W+3:0]     blank_prod = ref_len * sel_blk;
    wire [CNT_W-1:0]     blank_len  = blank_prod[BLK_SHIFT +: CNT_W];

    // output only moves when no blank window is open, then opens a new one;
    // comparator chatter inside the window is ignored entirely
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            out_reg       <= 1'b0;
            pulse_cnt_reg <= '0;
            last_ref_reg  <= '0;
            blank_cnt_reg <= '0;
        end else if (clk_en) begin
            if (out_change) begin
                out_reg       <= sensor_cmp;
                blank_cnt_reg <= blank_len;
                pulse_cnt_reg <= '0;
                if (ref_ending) begin
                    last_ref_reg <= pulse_cnt_reg;
                end
            end else begin
                if (blank_cnt_reg != '0) begin
                    blank_cnt_reg <= blank_cnt_reg - CNT_W'(1);
                end
                // saturate so a stalled wheel does not wrap the width
                if (pulse_cnt_reg != '1) begin
                    pulse_cnt_reg <= pulse_cnt_reg + CNT_W'(1);
                end
            end
        end
    end
    assign conditioned_tooth_out = out_reg;

    // ************************************************************
    // tachometer divider
    // ************************************************************
    logic [2:0]          tach_cnt_reg;               // rising edges since last toggle
    logic                tach_reg;                   // tacho level
    logic                out_prev_reg;               // for rising edge detection

    wire                 out_rise = out_reg & ~out_prev_reg;

    // divide 0 passes the tooth straight through; n toggles every n edges,
    // a total ratio of 2n
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tach_cnt_reg <= 3'h0;
            tach_reg     <= 1'b0;
            out_prev_reg <= 1'b0;
        end else if (clk_en) begin
            out_prev_reg <= out_reg;
            if (tach_div == 3'h0) begin
                tach_reg     <= out_reg;
                tach_cnt_reg <= 3'h0;
            end else if (out_rise) begin
                if (tach_cnt_reg + 3'h1 >= tach_div) begin
                    tach_reg     <= ~tach_reg;
                    tach_cnt_reg <= 3'h0;
                end else begin
                    tach_cnt_reg <= tach_cnt_reg + 3'h1;
                end
            end
        end
    end
    assign tacho_drive_out = tach_reg;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    crank_zero_sel_a: assert property (
        (clk_en && !auto_on && crank_reg == 8'h00)
            |=> (thresh_dac_code == $past(run_reg[THR_LSB +: 4])))
        else $error("zero cranking set did not select running set");

    crank_sel_a: assert property (
        (clk_en && !auto_on && crank_reg != 8'h00)
            |=> (thresh_dac_code == $past(crank_reg[THR_LSB +: 4])))
        else $error("nonzero cranking set not selected");

    dac_follow_a: assert property (
        (clk_en && !auto_on) |=> (thresh_dac_code == $past(sel_thr)))
        else $error("dac code does not follow active threshold");

    reset_default_a: assert property (
        disable iff (1'b0) !rst_n |=> (run_reg == RUN_RST && thresh_dac_code == 4'h5))
        else $error("reset threshold code is not 0101");

    blank_hold_a: assert property (
        (clk_en && blank_cnt_reg != '0) |=> $stable(conditioned_tooth_out))
        else $error("tooth output moved inside blank window");

    out_follow_a: assert property (
        (clk_en && out_change) |=> (conditioned_tooth_out == $past(sensor_cmp)
                                   && blank_cnt_reg == $past(blank_len)))
        else $error("tooth output or blank load wrong on change");

    tach_pass_a: assert property (
        (clk_en && tach_div == 3'h0) |=> (tacho_drive_out == $past(conditioned_tooth_out)))
        else $error("undivided tacho does not follow tooth");

    auto_max_a: assert property (
        (clk_en && auto_on && zc_rise) |=> (thresh_dac_code == THR_MAX))
        else $error("zero crossing did not force maximum threshold");

    write_effect_a: assert property (
        (clk_en && wr_en && aw_addr_reg == CRANK_OFS) |=> (crank_reg == $past(w_data_reg)))
        else $error("cranking write not applied");
endmodule
`default_nettype wire

//--- verification/sensor_model.sv
// sensor side model: square tooth wave with an optional commanded dropout
`default_nettype none
module sensor_model (
    input  wire logic        core_clk,
    input  wire logic [15:0] high_len,    // cycles above threshold
    input  wire logic [15:0] low_len,     // cycles below threshold
    input  wire logic        glitch_en,   // inject a one-cycle dropout
    input  wire logic [15:0] glitch_off,  // dropout position in the high phase
    output logic             sensor_cmp,
    output logic             sensor_zero_pos
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] ph_reg = 16'h0000;  // position within one tooth period
    // ************************************************************
    // tooth phase, wraps so a shortened period never runs away
    // ************************************************************
    always @(posedge core_clk) begin
        if (ph_reg >= high_len + low_len - 16'h0001) begin
            ph_reg <= 16'h0000;
        end else begin
            ph_reg <= ph_reg + 16'h0001;
        end
    end
    // the sign never glitches, only the comparator does
    assign sensor_zero_pos = ph_reg < high_len;
    assign sensor_cmp      = sensor_zero_pos && !(glitch_en && ph_reg == glitch_off);
endmodule
`default_nettype wire

//--- verification/crank_tooth_conditioner_params_test.sv
// self-checking bench for the tooth conditioner parameter block
`default_nettype none
module test_crank_tooth_conditioner_params;
    timeunit 1ns;
    timeprecision 1ps;
    import tooth_pkg::*;
    localparam int HI = 32;   // high phase cycles
    localparam int LO = 96;   // low phase cycles
    localparam int GL = 12;   // dropout offset in the high phase
    logic        core_clk = 1'b0;
    logic        rst_n    = 1'b0;
    logic        clk_en   = 1'b1;
    logic        sensor_cmp, sensor_zero_pos, conditioned_tooth_out, tacho_drive_out;
    logic [3:0]  thresh_dac_code;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, r;
    logic [31:0] rdata, d, w;
    logic [15:0] low_len = 16'h0060;
    logic [7:0]  run_v, crank_v;
    int          seed = 22, bad_count = 0, n_tests = 0, cyc = 0, tr, hr, lowv;

    always #4 core_clk = ~core_clk;

    crank_tooth_conditioner_params u_dut (
        .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
        .sensor_cmp(sensor_cmp), .sensor_zero_pos(sensor_zero_pos),
        .thresh_dac_code(thresh_dac_code), .conditioned_tooth_out(conditioned_tooth_out),
        .tacho_drive_out(tacho_drive_out),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );
    sensor_model u_sensor (
        .core_clk(core_clk), .high_len(16'(HI)), .low_len(low_len), .glitch_en(1'b1),
        .glitch_off(16'(GL)), .sensor_cmp(sensor_cmp), .sensor_zero_pos(sensor_zero_pos)
    );
    // ************************************************************
    // helpers
    // ************************************************************
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // write: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
        awaddr <= a; wdata <= v; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge core_clk);
    endtask
    function automatic logic [3:0] exp_code(input logic [7:0] run, input logic [7:0] crank);
        return (crank != 8'h00) ? crank[7:4] : run[7:4];
    endfunction
    // rises per period: the dropout survives only when blanking ends before it
    function automatic int exp_rises(input logic hl, input logic [3:0] code);
        int b;
        b = ((hl ? LO : HI) * int'(code)) >>> 5;
        return (b + 2 < GL) ? 2 : 1;
    endfunction
    // settle, move into the low phase, then count output rises
    task automatic measure(input int n);
        logic pt, ph;
        repeat (256) @(posedge core_clk);
        do @(posedge core_clk); while (sensor_zero_pos !== 1'b0);
        repeat (20) @(posedge core_clk);
        tr = 0; hr = 0; pt = conditioned_tooth_out; ph = tacho_drive_out;
        repeat (n) begin
            @(posedge core_clk);
            if (conditioned_tooth_out && !pt) tr++;
            if (tacho_drive_out && !ph) hr++;
            pt = conditioned_tooth_out;
            ph = tacho_drive_out;
        end
    endtask
    // hang guard, generous beyond the expected run length
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 30000) begin
            bad_count++;
            $display("ERROR t=%0t timeout", $time);
            end_sim();
        end
    end
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        logic [7:0]  ofs [4] = '{RUN_OFS, CRANK_OFS, AUTO_OFS, MISC_OFS};
        logic [7:0]  rst [4] = '{RUN_RST, CRANK_RST, AUTO_RST, MISC_RST};
        logic [3:0]  bc [4]  = '{4'h0, 4'h8, 4'h8, 4'hF};
        logic        bh [4]  = '{1'b0, 1'b0, 1'b1, 1'b0};
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        chk(32'(thresh_dac_code), 32'h5);
        for (int i = 0; i < 4; i++) begin
            rd(ofs[i]);
            chk(d, 32'(rst[i]));
        end
        rd(STAT_OFS);
        chk(d & 32'h0000_00F8, 32'h0000_0050);
        wr(8'h14, 32'h0000_00FF, 4'hF);
        chk(32'(r), 32'(RESP_SLV));
        rd(8'h14);
        chk(d, 32'h0000_0000);
        $display("test reset_and_map done");
        // random sets, every third with a cleared cranking register
        for (int i = 0; i < 8; i++) begin
            w = $random(seed);
            run_v = w[7:0];
            wr(RUN_OFS, w, 4'hF);
            w = $random(seed);
            if (i % 3 == 0) w[7:0] = 8'h00;
            crank_v = w[7:0];
            wr(CRANK_OFS, w, 4'hF);
            repeat (2) @(posedge core_clk);
            chk(32'(thresh_dac_code), 32'(exp_code(run_v, crank_v)));
            rd(CRANK_OFS);
            chk(d, {24'h00_0000, crank_v});
            rd(STAT_OFS);
            chk(32'(d[7:3]), 32'({exp_code(run_v, crank_v), crank_v != 8'h00}));
        end
        wr(CRANK_OFS, 32'h0000_0000, 4'hF);
        repeat (2) @(posedge core_clk);
        chk(32'(thresh_dac_code), 32'(run_v[7:4]));
        wr(RUN_OFS, 32'h0000_00A0, 4'h0);
        rd(RUN_OFS);
        chk(d, {24'h00_0000, run_v});
        $display("test parameter_select done");
        // blanking: dropout passes or is held off by the one-shot
        for (int i = 0; i < 4; i++) begin
            wr(RUN_OFS, {24'h00_0000, 4'h5, bc[i]}, 4'hF);
            wr(MISC_OFS, 32'(bh[i]) << HLREF_BIT, 4'hF);
            measure(4 * (HI + LO));
            chk(32'(tr), 32'(4 * exp_rises(bh[i], bc[i])));
        end
        $display("test blanking done");
        // tacho divide from pass-through up to three
        for (int dv = 0; dv < 4; dv++) begin
            wr(MISC_OFS, 32'(dv) << DIV_LSB, 4'hF);
            measure(12 * (HI + LO));
            chk(32'(tr), 32'd12);
            chk(32'(hr), (dv == 0) ? 32'd12 : 32'(6 / dv));
        end
        $display("test tacho done");
        // clock enable low: tooth and tacho outputs hold while the wheel turns
        clk_en <= 1'b0;
        @(posedge core_clk);
        w[1:0] = {conditioned_tooth_out, tacho_drive_out};
        lowv = 0;
        repeat (2 * (HI + LO)) begin
            @(posedge core_clk);
            if ({conditioned_tooth_out, tacho_drive_out} !== w[1:0]) lowv++;
        end
        clk_en <= 1'b1;
        chk(32'(lowv), 32'h0000_0000);
        $display("test clock_enable done");
        // automatic mode: one code every 33 cycles (load 32 plus the reload
        // edge), decay from maximum down to 3
        low_len <= 16'h0258;
        wr(AUTO_OFS, 32'h0000_0010, 4'hF);
        wr(RUN_OFS, 32'h0000_0030, 4'hF);
        wr(MISC_OFS, 32'h0000_0080, 4'hF);
        do @(posedge core_clk); while (sensor_zero_pos !== 1'b0);
        do @(posedge core_clk); while (sensor_zero_pos !== 1'b1);
        lowv = 0;
        for (int k = 1; k <= 440; k++) begin
            @(posedge core_clk);
            if (thresh_dac_code < 4'h3) lowv++;
            if (k == 3) chk(32'(thresh_dac_code), 32'(THR_MAX));
            if (k == 195) chk(32'(thresh_dac_code inside {[4'h8 : 4'hA]}), 32'd1);
        end
        chk(32'(thresh_dac_code), 32'h3);
        chk(32'(lowv), 32'd0);
        $display("test auto_mode done");
        end_sim();
    end
endmodule
`default_nettype wire
